/* File: inc/intc_pkg.sv */
// Package with register layouts, codes and timing counts for the interrupt controller.
package intc_pkg;
	localparam int LEVELS = 6;
	localparam int PIN_LEVEL_0 = 2;
	localparam int PIN_LEVEL_1 = 3;
	localparam int PIN_LEVEL_2 = 1;
	localparam int PIN_LEVEL_3 = 0;
	localparam int PRI_C_BIT = 1;
	localparam int PRI_B_BIT = 2;
	localparam int PRI_A_BIT = 5;
	localparam int PRI_G0_BIT = 0;
	localparam int PRI_G1_BIT = 3;
	localparam int PRI_G2_BIT = 4;
	localparam int MASTER_BIT = 7;
	localparam logic [7:0] MASK_RW_BITS = 8'hBF;
	localparam logic [7:0] REQ_RW_BITS = 8'h3F;
	localparam logic [7:0] PRIORITY_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] VECTOR_STEP = 8'h02;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] REG_PRIORITY = 2'h0;
	localparam logic [1:0] REG_MASK = 2'h1;
	localparam logic [1:0] REG_REQUEST = 2'h2;
	localparam logic [2:0] ORDER_CAB = 3'h1;
	localparam logic [2:0] ORDER_ABC = 3'h2;
	localparam logic [2:0] ORDER_ACB = 3'h3;
	localparam logic [2:0] ORDER_BCA = 3'h4;
	localparam logic [2:0] ORDER_CBA = 3'h5;
	localparam logic [2:0] ORDER_BAC = 3'h6;
endpackage

/* File: inc/edge_if.sv */
// Interface carrying one pin and its synchronised request between capture stage and controller.
`timescale 1ns/10ps
interface edge_if;
	logic pin;
	logic request;
	modport stage (input pin, output request);
	modport ctrl (output pin, input request);
endinterface

/* File: src/pin_edge_capture.sv */
// Falling edge capture and two-stage synchroniser for one external request pin.
`timescale 1ns/10ps
module pin_edge_capture
(
	input wire logic clk,
	input wire logic rst,
	edge_if.stage e
);
	logic pin_prev_q;
	logic capture_q;
	logic sync1_q;
	logic sync2_q;
	logic done_q;
	wire fall = pin_prev_q & ~e.pin;

	// The capture flop holds the edge until the synchronised copy has been handed on.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_prev_q <= 1'b1;
			capture_q <= 1'b0;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			pin_prev_q <= e.pin;
			capture_q <= fall | (capture_q & ~sync2_q);
			sync1_q <= capture_q;
			sync2_q <= sync1_q;
			done_q <= sync2_q;
		end
	end

	// One pulse per edge reaches the controller, two clocks behind the pin capture.
	assign e.request = sync2_q & ~done_q;
endmodule // pin_edge_capture

/* File: src/interrupt_controller.sv */
// Six-level interrupt controller: request latch, mask, priority and CPU sequencer hooks.
//
// Function
// - Falling edges on port three pins 2, 3, 1 raise levels 0, 1, 2.
// - Pin edge sets capture flop; two flops synchronise it to the clock.
// - Level n vectors at program memory pair 2n, 2n+1.
// - Level 3 uses pin 0 only while serial receiver disabled, else internal.
// - Enabled receiver raises level 3 on each completed byte.
// - Level 4 from transmit-empty if transmitter enabled, else timer zero end-of-count.
// - Timer one end-of-count requests level 5.
// - Request leading edge captured and held until sampling before opcode fetch.
// - External requests effectively sampled three clocks earlier than internal ones.
// - Sampling moves captures into request flops; interrupt clears only the winner.
// - Request flops are readable and writable by software.
// - Priority register write-only; groups A=3,5 B=0,2 C=1,4; bits 6,7 unused.
// - Bits 1, 2, 5 select in-group order; 1 reverses it.
// - Bits 4,3,0 encode group order; 000 and 111 unused.
// - Mask bits 0..5 enable their levels when set.
// - Mask bit 7 is master enable, set by enable and cleared by disable.
// - Master enable cleared in interrupt cycle, set after interrupt return.
// - Request bits 0..5 hold pending levels 0..5.
// - Request register held cleared until first enable-interrupts instruction.
// - Core pushes PC low, PC high, flags, then fetches vector.
`timescale 1ns/10ps
module interrupt_controller
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [3:0] PORT_THREE_IN,
	input wire logic SERIAL_RX_ENABLE,
	input wire logic SERIAL_RX_BYTE_DONE,
	input wire logic SERIAL_TX_ENABLE,
	input wire logic SERIAL_TX_EMPTY,
	input wire logic TIMER_ZERO_END,
	input wire logic TIMER_ONE_END,
	input wire logic SAMPLE,
	input wire logic INT_CYCLE,
	input wire logic ENABLE_INTERRUPTS_INSTR,
	input wire logic DISABLE_INTERRUPTS_INSTR,
	input wire logic INTERRUPT_RETURN_INSTR,
	input wire logic REG_WRITE,
	input wire logic REG_READ,
	input wire logic [1:0] REG_SELECT,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic INT_REQUEST,
	output logic [2:0] INT_LEVEL,
	output logic [7:0] INT_VECTOR
);
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_SERVICE = 2'b01
	} svc_state_t;

	svc_state_t state_q;
	svc_state_t state_d;
	logic [7:0] priority_order_reg_q;
	logic [7:0] level_mask_reg_q;
	logic [5:0] request_q;
	logic [5:0] capture_q;
	logic armed_q;
	logic [7:0] rdata_q;
	logic [2:0] level_q;
	logic [7:0] vector_q;
	logic [3:0] pin_request;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_pin
			edge_if pin_link ();
			assign pin_link.pin = PORT_THREE_IN[gi];
			assign pin_request[gi] = pin_link.request;
			pin_edge_capture u_cap
			(
				.clk(MCLK),
				.rst(RST),
				.e(pin_link.stage)
			);
		end
	endgenerate

	wire request_level_0 = pin_request[intc_pkg::PIN_LEVEL_0];
	wire request_level_1 = pin_request[intc_pkg::PIN_LEVEL_1];
	wire request_level_2 = pin_request[intc_pkg::PIN_LEVEL_2];
	wire request_level_3 = SERIAL_RX_ENABLE ? SERIAL_RX_BYTE_DONE
		: pin_request[intc_pkg::PIN_LEVEL_3];
	// The two sources are exclusive by configuration; transmitter wins if both are set.
	wire request_level_4 = SERIAL_TX_ENABLE ? SERIAL_TX_EMPTY : TIMER_ZERO_END;
	wire request_level_5 = TIMER_ONE_END;
	wire [5:0] raw_req = {request_level_5, request_level_4, request_level_3,
		request_level_2, request_level_1, request_level_0};

	wire master_enable_bit = level_mask_reg_q[intc_pkg::MASTER_BIT];
	wire [5:0] enabled = request_q & level_mask_reg_q[5:0];

	// Priority ranking: three groups each with two members in a selectable order.
	wire a_rev = priority_order_reg_q[intc_pkg::PRI_A_BIT];
	wire b_rev = priority_order_reg_q[intc_pkg::PRI_B_BIT];
	wire c_rev = priority_order_reg_q[intc_pkg::PRI_C_BIT];
	wire [2:0] a_hi = a_rev ? 3'h3 : 3'h5;
	wire [2:0] a_lo = a_rev ? 3'h5 : 3'h3;
	wire [2:0] b_hi = b_rev ? 3'h0 : 3'h2;
	wire [2:0] b_lo = b_rev ? 3'h2 : 3'h0;
	wire [2:0] c_hi = c_rev ? 3'h4 : 3'h1;
	wire [2:0] c_lo = c_rev ? 3'h1 : 3'h4;
	wire [2:0] group_code = {priority_order_reg_q[intc_pkg::PRI_G2_BIT],
		priority_order_reg_q[intc_pkg::PRI_G1_BIT], priority_order_reg_q[intc_pkg::PRI_G0_BIT]};

	logic [1:0] g_first;
	logic [1:0] g_second;
	logic [1:0] g_third;
	logic order_valid;

	// Groups are coded 0=A, 1=B, 2=C.
	always_comb
	begin
		order_valid = 1'b1;
		g_first = 2'd0;
		g_second = 2'd1;
		g_third = 2'd2;
		case (group_code)
			intc_pkg::ORDER_CAB:
			begin
				g_first = 2'd2;
				g_second = 2'd0;
				g_third = 2'd1;
			end
			intc_pkg::ORDER_ABC:
			begin
				g_first = 2'd0;
				g_second = 2'd1;
				g_third = 2'd2;
			end
			intc_pkg::ORDER_ACB:
			begin
				g_first = 2'd0;
				g_second = 2'd2;
				g_third = 2'd1;
			end
			intc_pkg::ORDER_BCA:
			begin
				g_first = 2'd1;
				g_second = 2'd2;
				g_third = 2'd0;
			end
			intc_pkg::ORDER_CBA:
			begin
				g_first = 2'd2;
				g_second = 2'd1;
				g_third = 2'd0;
			end
			intc_pkg::ORDER_BAC:
			begin
				g_first = 2'd1;
				g_second = 2'd0;
				g_third = 2'd2;
			end
			default:
			begin
				// Unused codes rank nothing, so no vectored interrupt is taken.
				order_valid = 1'b0;
			end
		endcase
	end

	function automatic logic [2:0] grp_hi(input logic [1:0] g, input logic [2:0] ah,
		input logic [2:0] bh, input logic [2:0] ch);
		grp_hi = (g == 2'd0) ? ah : ((g == 2'd1) ? bh : ch);
	endfunction

	wire [2:0] rank0 = grp_hi(g_first, a_hi, b_hi, c_hi);
	wire [2:0] rank1 = grp_hi(g_first, a_lo, b_lo, c_lo);
	wire [2:0] rank2 = grp_hi(g_second, a_hi, b_hi, c_hi);
	wire [2:0] rank3 = grp_hi(g_second, a_lo, b_lo, c_lo);
	wire [2:0] rank4 = grp_hi(g_third, a_hi, b_hi, c_hi);
	wire [2:0] rank5 = grp_hi(g_third, a_lo, b_lo, c_lo);

	wire winner_valid = order_valid & (|enabled);
	wire [2:0] winner = enabled[rank0] ? rank0 :
		enabled[rank1] ? rank1 :
		enabled[rank2] ? rank2 :
		enabled[rank3] ? rank3 :
		enabled[rank4] ? rank4 : rank5;

	wire take = INT_CYCLE & (state_q == ST_IDLE) & master_enable_bit & winner_valid;
	wire [5:0] winner_onehot = 6'h01 << winner;
	wire req_write = REG_WRITE & (REG_SELECT == intc_pkg::REG_REQUEST);
	wire mask_write = REG_WRITE & (REG_SELECT == intc_pkg::REG_MASK);
	wire prio_write = REG_WRITE & (REG_SELECT == intc_pkg::REG_PRIORITY);

	// Software write replaces the flops, then sampled requests are ORed in so none is lost.
	wire [5:0] req_base = req_write ? REG_WDATA[5:0] : request_q;
	wire [5:0] req_clr = take ? winner_onehot : 6'h00;
	wire [5:0] sampled = SAMPLE ? capture_q : 6'h00;
	wire [5:0] request_d = armed_q ? ((req_base & ~req_clr) | sampled) : 6'h00;
	wire [5:0] capture_d = armed_q ? ((SAMPLE ? 6'h00 : capture_q) | raw_req) : 6'h00;

	wire master_set = ENABLE_INTERRUPTS_INSTR | INTERRUPT_RETURN_INSTR;
	wire master_clr = DISABLE_INTERRUPTS_INSTR | take;
	wire [7:0] mask_base = mask_write ? (REG_WDATA & intc_pkg::MASK_RW_BITS) : level_mask_reg_q;
	wire master_d = master_set ? 1'b1 : (master_clr ? 1'b0 : mask_base[intc_pkg::MASTER_BIT]);
	wire [7:0] mask_d = {master_d, 1'b0, mask_base[5:0]};

	wire [7:0] read_mux = (REG_SELECT == intc_pkg::REG_MASK) ? level_mask_reg_q :
		(REG_SELECT == intc_pkg::REG_REQUEST) ? {2'b00, request_q} : 8'h00;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (take)
				begin
					state_d = ST_SERVICE;
				end
			end
			ST_SERVICE:
			begin
				if (INTERRUPT_RETURN_INSTR)
				begin
					state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			state_q <= ST_IDLE;
			priority_order_reg_q <= intc_pkg::PRIORITY_RESET;
			level_mask_reg_q <= intc_pkg::MASK_RESET;
			request_q <= 6'h00;
			capture_q <= 6'h00;
			armed_q <= 1'b0;
			rdata_q <= 8'h00;
			level_q <= 3'h0;
			vector_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			if (prio_write)
			begin
				priority_order_reg_q <= REG_WDATA;
			end
			level_mask_reg_q <= mask_d;
			request_q <= request_d;
			capture_q <= capture_d;
			armed_q <= armed_q | ENABLE_INTERRUPTS_INSTR;
			if (REG_READ)
			begin
				rdata_q <= read_mux;
			end
			if (take)
			begin
				level_q <= winner;
				vector_q <= 8'(winner) * intc_pkg::VECTOR_STEP;
			end
		end
	end

	assign INT_REQUEST = master_enable_bit & winner_valid & (state_q == ST_IDLE);
	assign REG_RDATA = rdata_q;
	assign INT_LEVEL = level_q;
	assign INT_VECTOR = vector_q;
endmodule // interrupt_controller

/* File: sim/intc_properties.sv */
// Port-level assertions for the interrupt controller.
`timescale 1ns/10ps
module intc_properties
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SAMPLE,
	input wire logic INT_CYCLE,
	input wire logic ENABLE_INTERRUPTS_INSTR,
	input wire logic DISABLE_INTERRUPTS_INSTR,
	input wire logic INTERRUPT_RETURN_INSTR,
	input wire logic REG_WRITE,
	input wire logic REG_READ,
	input wire logic [1:0] REG_SELECT,
	input wire logic [7:0] REG_RDATA,
	input wire logic INT_REQUEST,
	input wire logic [2:0] INT_LEVEL,
	input wire logic [7:0] INT_VECTOR
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// A mask write may set the master bit too, so it counts as a setter.
	wire take = INT_CYCLE && INT_REQUEST;
	wire sets = ENABLE_INTERRUPTS_INSTR || INTERRUPT_RETURN_INSTR || REG_WRITE;
	wire cause = SAMPLE || sets;
	wire rd_pri = REG_READ && REG_SELECT == intc_pkg::REG_PRIORITY;
	wire rd_req = REG_READ && REG_SELECT == intc_pkg::REG_REQUEST;
	vec_pair_a: assert property (INT_VECTOR == {4'h0, INT_LEVEL, 1'b0}) else $error("bad vector");
	level_range_a: assert property (INT_LEVEL < 3'h6) else $error("bad level");
	take_drop_a: assert property (take && !sets |=> !INT_REQUEST) else $error("request after take");
	level_hold_a: assert property (!take |=> $stable(INT_LEVEL)) else $error("level moved");
	disable_block_a: assert property (DISABLE_INTERRUPTS_INSTR && !sets |=> !INT_REQUEST) else $error("no block");
	rise_cause_a: assert property ($rose(INT_REQUEST) |-> $past(cause)) else $error("request uncaused");
	rdata_hold_a: assert property (!REG_READ |=> $stable(REG_RDATA)) else $error("read data moved");
	pri_wo_a: assert property (rd_pri |=> REG_RDATA == 8'h00) else $error("priority readable");
	req_top_a: assert property (rd_req |=> REG_RDATA[7:6] == 2'h0) else $error("request top bits set");
	cover property (take);
	cover property (rd_req);
	cover property ($rose(INT_REQUEST));
endmodule // intc_properties

/* File: sim/core_model.sv */
// Sequencer stand-in: periodic sample pulses and interrupt cycles on request.
`timescale 1ns/10ps
module core_model
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic int_request,
	input wire logic take_allow,
	output logic sample,
	output logic int_cycle
);
	logic [1:0] phase_q;
	// A sample every fourth cycle stands for a stream of short instructions.
	always_ff @(posedge mclk)
	begin
		phase_q <= rst ? 2'h0 : phase_q + 2'h1;
		sample <= !rst && phase_q == 2'h3;
		int_cycle <= !rst && take_allow && int_request && !int_cycle;
	end
endmodule // core_model

/* File: sim/six_level_interrupt_controller_tb.sv */
// Self-checking bench for the six-level interrupt controller.
`timescale 1ns/10ps
module six_level_interrupt_controller_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] pins = 4'hF;
	logic [1:0] en = 2'h0;
	logic [3:0] iv = 4'h0;
	logic [2:0] ins = 3'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic allow = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdata;
	logic [7:0] vec;
	logic [2:0] lvl;
	logic irq;
	logic sample;
	logic icyc;
	logic [31:0] seed = 32'h0000000C;
	logic [7:0] p;
	logic [7:0] m;
	logic [7:0] r;
	logic [2:0] w;
	int failures = 0;
	int n_compared = 0;
	// Packed as pins, pulses {timer one, timer zero, tx empty, rx done}, enables {tx,rx}, expected request bits.
	logic [15:0] tab[11] = '{16'h4001, 16'h8002, 16'h2004, 16'h1008, 16'h1040, 16'h0148,
		16'h0290, 16'h0410, 16'h0480, 16'h0820, 16'h0100};
	always #50 mclk = ~mclk;
	interrupt_controller interrupt_controller_i (.MCLK(mclk), .RST(rst), .PORT_THREE_IN(pins),
		.SERIAL_RX_ENABLE(en[0]), .SERIAL_RX_BYTE_DONE(iv[0]), .SERIAL_TX_ENABLE(en[1]),
		.SERIAL_TX_EMPTY(iv[1]), .TIMER_ZERO_END(iv[2]), .TIMER_ONE_END(iv[3]), .SAMPLE(sample),
		.INT_CYCLE(icyc), .ENABLE_INTERRUPTS_INSTR(ins[0]), .DISABLE_INTERRUPTS_INSTR(ins[1]),
		.INTERRUPT_RETURN_INSTR(ins[2]), .REG_WRITE(wr), .REG_READ(rd), .REG_SELECT(sel),
		.REG_WDATA(wd), .REG_RDATA(rdata), .INT_REQUEST(irq), .INT_LEVEL(lvl), .INT_VECTOR(vec));
	core_model core_model_i (.mclk(mclk), .rst(rst), .int_request(irq), .take_allow(allow),
		.sample(sample), .int_cycle(icyc));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Group digits: A=0, B=1, C=2, highest group first; 7 means nothing wins.
	function automatic logic [2:0] win(input logic [7:0] pr, input logic [5:0] pend);
		int go[8] = '{0, 201, 12, 21, 120, 210, 102, 0};
		int div = 100;
		int g;
		int hi;
		int lo;
		// Unused group codes rank nothing, so no level can win.
		if (go[{pr[4], pr[3], pr[0]}] == 0)
			return 3'h7;
		for (int i = 0; i < 3; i++)
		begin
			g = go[{pr[4], pr[3], pr[0]}] / div % 10;
			div = div / 10;
			hi = g == 0 ? (pr[5] ? 3 : 5) : g == 1 ? (pr[2] ? 0 : 2) : (pr[1] ? 4 : 1);
			lo = g == 0 ? 8 - hi : g == 1 ? 2 - hi : 5 - hi;
			if (pend[hi])
				return hi[2:0];
			if (pend[lo])
				return lo[2:0];
		end
		return 3'h7;
	endfunction
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic wrt, input logic [1:0] s, input logic [7:0] d);
		@(posedge mclk);
		wr <= wrt;
		rd <= !wrt;
		sel <= s;
		wd <= d;
		@(posedge mclk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask
	task automatic instr(input logic [2:0] i);
		@(posedge mclk);
		ins <= i;
		@(posedge mclk);
		ins <= 3'h0;
	endtask
	task automatic end_of_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge mclk);
		failures++;
		end_of_test();
	end
	initial
	begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk({4'h0, irq, lvl}, 8'h00, "reset outputs");
		bus(1'b1, intc_pkg::REG_REQUEST, 8'h3F);
		bus(1'b0, intc_pkg::REG_REQUEST, 8'h00);
		chk(rdata, 8'h00, "request before enable");
		bus(1'b1, intc_pkg::REG_PRIORITY, 8'h01);
		bus(1'b1, intc_pkg::REG_MASK, 8'h7F);
		bus(1'b1, intc_pkg::REG_REQUEST, 8'h00);
		bus(1'b0, intc_pkg::REG_MASK, 8'h00);
		chk(rdata, 8'h3F, "mask");
		bus(1'b0, intc_pkg::REG_PRIORITY, 8'h00);
		chk(rdata, 8'h00, "priority read");
		instr(3'h1);
		bus(1'b0, intc_pkg::REG_MASK, 8'h00);
		chk(rdata, 8'hBF, "master set");
		instr(3'h2);
		bus(1'b1, intc_pkg::REG_MASK, 8'h00);
		instr(3'h1);
		foreach (tab[k])
		begin
			bus(1'b1, intc_pkg::REG_REQUEST, 8'h00);
			@(posedge mclk);
			en <= tab[k][7:6];
			pins <= ~tab[k][15:12];
			iv <= tab[k][11:8];
			@(posedge mclk);
			pins <= 4'hF;
			iv <= 4'h0;
			repeat (12) @(posedge mclk);
			bus(1'b0, intc_pkg::REG_REQUEST, 8'h00);
			chk(rdata, {2'h0, tab[k][5:0]}, "source request");
		end
		// Every group code is visited, the two unused ones included.
		for (int n = 0; n < 16; n++)
		begin
			w = 3'(n % 8);
			p = (8'(xs()) & 8'hE6) | {3'h0, w[2:1], 2'h0, w[0]};
			m = 8'(xs()) & 8'h3F;
			r = 8'(xs());
			instr(3'h2);
			bus(1'b1, intc_pkg::REG_PRIORITY, p);
			bus(1'b1, intc_pkg::REG_MASK, m);
			bus(1'b1, intc_pkg::REG_REQUEST, r);
			instr(3'h1);
			w = win(p, r[5:0] & m[5:0]);
			repeat (2) @(posedge mclk);
			allow <= 1'b1;
			#1;
			chk({7'h0, irq}, {7'h0, w != 3'h7}, "request line");
			repeat (4) @(posedge mclk);
			allow <= 1'b0;
			#1;
			chk({7'h0, irq}, 8'h00, "request after take");
			if (w != 3'h7)
			begin
				chk(vec, {4'h0, w, 1'b0}, "vector");
				chk({5'h0, lvl}, {5'h0, w}, "level");
			end
			bus(1'b0, intc_pkg::REG_REQUEST, 8'h00);
			r = {2'h0, r[5:0] & ~(6'h01 << w)};
			chk(rdata, r, "request after take");
			instr(3'h4);
			#1;
			chk({7'h0, irq}, {7'h0, win(p, r[5:0] & m[5:0]) != 3'h7}, "request after return");
		end
		end_of_test();
	end
endmodule // six_level_interrupt_controller_tb
bind interrupt_controller intc_properties intc_properties_i (.MCLK(MCLK), .RST(RST), .SAMPLE(SAMPLE),
	.INT_CYCLE(INT_CYCLE), .ENABLE_INTERRUPTS_INSTR(ENABLE_INTERRUPTS_INSTR),
	.DISABLE_INTERRUPTS_INSTR(DISABLE_INTERRUPTS_INSTR), .INTERRUPT_RETURN_INSTR(INTERRUPT_RETURN_INSTR),
	.REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_SELECT(REG_SELECT), .REG_RDATA(REG_RDATA),
	.INT_REQUEST(INT_REQUEST), .INT_LEVEL(INT_LEVEL), .INT_VECTOR(INT_VECTOR));
